// ==== src/eag_pkg.sv ====
/*
  Package for the effective address generator: operand sizes, address
  modes, immediate classes, decoded register selects and carrier structs.
  Assumes a single 32-bit core clock domain; no software registers.
*/
package eag_pkg;

  // ------------------------------------------------------------
  // widths and constants
  // ------------------------------------------------------------
  localparam int unsigned       DATA_W      = 32;
  localparam logic [31:0]       PC_STEP     = 32'h0000_0004;
  localparam logic [31:0]       LONG_ALIGN  = 32'hFFFF_FFFC;
  localparam logic [1:0]        TRAP_SHIFT  = 2'h2;
  localparam logic [1:0]        BRANCH_SHIFT = 2'h1;
  localparam logic [31:0]       ADDR_RESET  = 32'h0000_0000;

  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_QUAD = 2'b11
  } eag_size_e;

  typedef enum logic [2:0] {
    MODE_REG_DISP4  = 3'b000,
    MODE_REG_INDEX  = 3'b001,
    MODE_BASE_DISP8 = 3'b010,
    MODE_BASE_INDEX = 3'b011,
    MODE_PC_BRANCH  = 3'b100,
    MODE_REG_BRANCH = 3'b101,
    MODE_PC_LOAD    = 3'b110
  } eag_mode_e;

  typedef enum logic [1:0] {
    IMM_ZERO_EXT = 2'b00,
    IMM_SIGN_EXT = 2'b01,
    IMM_TRAP     = 2'b10
  } eag_imm_e;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    eag_mode_e   mode;
    eag_size_e   size;
    logic [11:0] disp;
    logic        privileged;
    logic [31:0] source_value;
    logic [31:0] global_base_register;
    logic [31:0] index_register_zero;
    logic [31:0] pc;
  } eag_addr_req_s;

  typedef struct packed {
    logic        valid;
    eag_imm_e    kind;
    logic [7:0]  imm;
  } eag_imm_req_s;

  typedef struct packed {
    logic [3:0] destination_register_field;
    logic [3:0] source_register_field;
    logic [2:0] pair_field;
    logic [1:0] vector_field;
  } eag_fields_s;

  typedef struct packed {
    logic [3:0] destination_register_index;
    logic [3:0] float_single_register;
    logic [3:0] double_pair_register;
    logic [3:0] extended_pair_register;
    logic [2:0] banked_general_register;
    logic [3:0] float_vector_register;
  } eag_selects_s;

endpackage

// ==== src/eag_effective_address_generator.sv ====
/*
  Effective address generator: forms operand and branch-target addresses,
  extends 8-bit immediates and decodes register-number fields. Results are
  registered one clock after a valid request.
  Assumes the decoder presents register contents already read out and the
  current privilege level; inputs are synchronous to i_mclk.
  Limitations: a refused privileged request leaves the address register
  untouched and raises a one-cycle fault pulse instead; mode code 7 and
  immediate kind code 3 have no instruction behind them and fall back to a
  zero address and to zero-extension. Additions wrap silently, so an
  address that crosses the top of the space comes back near zero; the
  load-store side must not rely on an overflow flag from this block.
  Results stand for one cycle as pulses; address and immediate then hold.
*/
// Notes on behaviour
// RULE_01 - register plus zero-extended disp4 scaled by size
// RULE_02 - register plus index register zero
// RULE_03 - base plus zero-extended disp8 scaled by size
// RULE_04 - base plus index register zero
// RULE_05 - pc plus four plus doubled signed disp12
// RULE_06 - pc plus four plus register contents
// RULE_07 - logic and test immediates zero-extended
// RULE_08 - move, add, compare immediates sign-extended
// RULE_09 - trap vector is zero-extended imm times four
// RULE_10 - four-bit field indexes register directly
// RULE_11 - three-bit field picks pair or bank
// RULE_12 - two-bit field picks vector base register
// RULE_13 - privileged requests refused outside privileged mode
// RULE_14 - scale factor 1,2,4,8 from operand size
// RULE_15 - longword pc load masks low two bits
// RULE_16 - additions wrap modulo two to thirty-two
`timescale 1ns/1ps
`default_nettype none

module eag_effective_address_generator (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_reset,
  // decoder side
  input  wire eag_pkg::eag_addr_req_s i_addr_req,
  input  wire eag_pkg::eag_imm_req_s  i_imm_req,
  input  wire eag_pkg::eag_fields_s   i_fields,
  input  wire logic                  i_privileged_mode,
  // load-store and branch side
  output logic                       o_addr_valid,
  output logic [31:0]                o_addr,
  output logic                       o_privilege_fault,
  output logic                       o_imm_valid,
  output logic [31:0]                o_imm,
  output eag_pkg::eag_selects_s      o_selects
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // displacement scaled by operand size; used for both disp4 and disp8
  function automatic logic [31:0] scale_disp(input logic [7:0] disp,
                                             input eag_pkg::eag_size_e size);
    logic [31:0] ext;
    ext = {24'h00_0000, disp};
    scale_disp = ext; // return value set on every path
    unique case (size)
      eag_pkg::SZ_BYTE: scale_disp = ext;                  // RULE_14
      eag_pkg::SZ_WORD: scale_disp = {ext[30:0], 1'b0};    // RULE_14
      eag_pkg::SZ_LONG: scale_disp = {ext[29:0], 2'b00};   // RULE_14
      eag_pkg::SZ_QUAD: scale_disp = {ext[28:0], 3'b000};  // RULE_14
    endcase
  endfunction

  // 32-bit add, carry out dropped on purpose: no overflow indication
  // the core treats addresses as a ring, so a wrap is never an error
  function automatic logic [31:0] add32(input logic [31:0] a, input logic [31:0] b);
    logic [32:0] full;
    full = {1'b0, a} + {1'b0, b};
    add32 = full[31:0]; // RULE_16
  endfunction

  // ------------------------------------------------------------
  // address datapath
  // ------------------------------------------------------------
  // next and registered values of the address group
  logic        next_addr_valid;
  logic [31:0] next_addr;
  logic        next_privilege_fault;
  logic        addr_valid;
  logic [31:0] addr;
  logic        privilege_fault;

  // one mode at a time; a refused request yields a fault pulse, no address
  always_comb begin
    logic [31:0] pc_plus4;
    logic [31:0] branch_off;
    logic [31:0] sum;
    // pc plus four is shared by both branch forms and the word load
    pc_plus4   = add32(i_addr_req.pc, eag_pkg::PC_STEP);
    branch_off = {{19{i_addr_req.disp[11]}}, i_addr_req.disp, 1'b0}; // RULE_05
    sum        = eag_pkg::ADDR_RESET;
    // mode code 7 has no addressing form and leaves a zero sum
    unique case (i_addr_req.mode)
      eag_pkg::MODE_REG_DISP4:
        sum = add32(i_addr_req.source_value,
                    scale_disp({4'h0, i_addr_req.disp[3:0]}, i_addr_req.size)); // RULE_01
      eag_pkg::MODE_REG_INDEX:
        sum = add32(i_addr_req.source_value, i_addr_req.index_register_zero); // RULE_02
      eag_pkg::MODE_BASE_DISP8:
        sum = add32(i_addr_req.global_base_register,
                    scale_disp(i_addr_req.disp[7:0], i_addr_req.size)); // RULE_03
      eag_pkg::MODE_BASE_INDEX:
        sum = add32(i_addr_req.global_base_register,
                    i_addr_req.index_register_zero); // RULE_04
      eag_pkg::MODE_PC_BRANCH:
        sum = add32(pc_plus4, branch_off); // RULE_05
      eag_pkg::MODE_REG_BRANCH:
        sum = add32(pc_plus4, i_addr_req.source_value); // RULE_06
      eag_pkg::MODE_PC_LOAD: begin
        // longword masks before adding; word form keeps the raw pc
        if (i_addr_req.size == eag_pkg::SZ_LONG) begin
          sum = add32(add32(i_addr_req.pc & eag_pkg::LONG_ALIGN, eag_pkg::PC_STEP),
                      scale_disp(i_addr_req.disp[7:0], eag_pkg::SZ_LONG)); // RULE_15
        end else begin
          sum = add32(pc_plus4, scale_disp(i_addr_req.disp[7:0], eag_pkg::SZ_WORD)); // RULE_15
        end
      end
      default: sum = eag_pkg::ADDR_RESET;
    endcase
    // refusal depends on the request and i_privileged_mode; the address register then holds
    next_privilege_fault = i_addr_req.valid & i_addr_req.privileged
                           & ~i_privileged_mode; // RULE_13
    next_addr_valid      = i_addr_req.valid & ~next_privilege_fault; // RULE_13
    // idle cycles and refusals keep the last accepted address on the pins
    next_addr            = next_addr_valid ? sum : addr;
  end

  // reset clears both pulses and parks the address at zero
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      addr_valid      <= 1'b0;
      addr            <= eag_pkg::ADDR_RESET;
      privilege_fault <= 1'b0;
    end else begin
      addr_valid      <= next_addr_valid;
      addr            <= next_addr;
      privilege_fault <= next_privilege_fault;
    end
  end

  // ------------------------------------------------------------
  // immediate extension
  // ------------------------------------------------------------
  // next and registered values of the immediate group
  logic        next_imm_valid;
  logic [31:0] next_imm;
  logic        imm_valid;
  logic [31:0] imm;

  // held value kept when idle so the output does not toggle needlessly
  always_comb begin
    next_imm_valid = i_imm_req.valid;
    next_imm       = imm;
    // kind code 3 names no instruction class and falls back to zero-extension
    if (i_imm_req.valid) begin
      unique case (i_imm_req.kind)
        eag_pkg::IMM_ZERO_EXT: next_imm = {24'h00_0000, i_imm_req.imm}; // RULE_07
        eag_pkg::IMM_SIGN_EXT: next_imm = {{24{i_imm_req.imm[7]}}, i_imm_req.imm}; // RULE_08
        eag_pkg::IMM_TRAP:     next_imm = {22'h00_0000, i_imm_req.imm, 2'b00}; // RULE_09
        default:               next_imm = {24'h00_0000, i_imm_req.imm};
      endcase
    end
  end

  // reset clears the pulse and the held immediate
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      imm_valid <= 1'b0;
      imm       <= eag_pkg::ADDR_RESET;
    end else begin
      imm_valid <= next_imm_valid;
      imm       <= next_imm;
    end
  end

  // ------------------------------------------------------------
  // register field decode
  // ------------------------------------------------------------
  // decoded register selects, registered to line up with the other results
  eag_pkg::eag_selects_s next_selects;
  eag_pkg::eag_selects_s selects;

  // pair codes step by two registers, vectors by four
  // the decode is pure wiring; only the register adds a cycle
  always_comb begin
    next_selects.destination_register_index = i_fields.destination_register_field; // RULE_10
    next_selects.float_single_register      = i_fields.source_register_field; // RULE_10
    next_selects.double_pair_register       = {i_fields.pair_field, 1'b0}; // RULE_11
    next_selects.extended_pair_register     = {i_fields.pair_field, 1'b0}; // RULE_11
    // bank numbers take the three-bit code unscaled
    next_selects.banked_general_register    = i_fields.pair_field; // RULE_11
    next_selects.float_vector_register      = {i_fields.vector_field, 2'b00}; // RULE_12
  end

  // selects follow the fields every cycle; no handshake
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      selects <= '0;
    end else begin
      selects <= next_selects;
    end
  end

  // ------------------------------------------------------------
  // result outputs
  // ------------------------------------------------------------
  // plain copies of registers, so every pin settles right after the edge
  assign o_addr_valid      = addr_valid;
  assign o_addr            = addr;
  assign o_privilege_fault = privilege_fault;
  assign o_imm_valid       = imm_valid;
  assign o_imm             = imm;
  assign o_selects         = selects;

endmodule

`default_nettype wire

// ==== testbench/eag_lsu_model.sv ====
/*
  load-store side model: takes each accepted address pulse.
  assumes it sits on the generator's result outputs, same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// ----
// address sink
// ----
module eag_lsu_model (
  // result side
  input wire logic        i_mclk,
  input wire logic        i_addr_valid,
  input wire logic [31:0] i_addr
);
  logic [31:0] last = 32'h0;
  // only the pulse counts; a held address is not a new access
  always @(posedge i_mclk) if (i_addr_valid) last <= i_addr;
endmodule
`default_nettype wire

// ==== testbench/eag_props.sv ====
/*
  port checker for the address generator.
  assumes it is bound onto eag_effective_address_generator.
*/
`timescale 1ns/1ps
`default_nettype none
module eag_props (
  // clock and reset
  input wire logic                   i_mclk,
  input wire logic                   i_reset,
  // decoder side
  input wire eag_pkg::eag_addr_req_s i_addr_req,
  input wire eag_pkg::eag_imm_req_s  i_imm_req,
  input wire eag_pkg::eag_fields_s   i_fields,
  input wire logic                   i_privileged_mode,
  // result side
  input wire logic                   o_addr_valid,
  input wire logic [31:0]            o_addr,
  input wire logic                   o_privilege_fault,
  input wire logic                   o_imm_valid,
  input wire logic [31:0]            o_imm,
  input wire eag_pkg::eag_selects_s  o_selects
);
  // ----
  // helpers
  // ----
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // sums taken one cycle early so $past sees a plain signal
  wire        ok  = i_addr_req.valid & ~(i_addr_req.privileged & ~i_privileged_mode);
  wire [2:0]  m   = i_addr_req.mode;
  wire [11:0] d   = i_addr_req.disp;
  wire [7:0]  ib  = i_imm_req.imm;
  wire [31:0] pc4 = i_addr_req.pc + 32'h4;
  wire [31:0] idx = i_addr_req.source_value + i_addr_req.index_register_zero;
  wire [31:0] gix = i_addr_req.global_base_register + i_addr_req.index_register_zero;
  wire [31:0] rbr = pc4 + i_addr_req.source_value;
  wire [31:0] pbr = pc4 + {{19{d[11]}}, d, 1'b0};
  wire [31:0] sx  = {{24{ib[7]}}, ib};
  wire [31:0] tv  = {22'h0, ib, 2'h0};
  // ----
  // checks
  // ----
  one_answer_a: assert property (i_addr_req.valid |=> o_addr_valid != o_privilege_fault)
    else $error("request answer count wrong");
  priv_refuse_a: assert property (i_addr_req.valid && !ok
    |=> o_privilege_fault && !o_addr_valid)
    else $error("user request not refused");
  index_sum_a: assert property (ok && m == 3'h1 |=> o_addr == $past(idx))
    else $error("index sum wrong");
  base_index_a: assert property (ok && m == 3'h3 |=> o_addr == $past(gix))
    else $error("base index sum wrong");
  pc_branch_a: assert property (ok && m == 3'h4 |=> o_addr == $past(pbr))
    else $error("pc branch target wrong");
  reg_branch_a: assert property (ok && m == 3'h5 |=> o_addr == $past(rbr))
    else $error("register branch target wrong");
  sign_imm_a: assert property (i_imm_req.valid
    && i_imm_req.kind == eag_pkg::IMM_SIGN_EXT |=> o_imm_valid && o_imm == $past(sx))
    else $error("signed immediate wrong");
  trap_vector_a: assert property (i_imm_req.valid
    && i_imm_req.kind == eag_pkg::IMM_TRAP |=> o_imm == $past(tv))
    else $error("trap vector wrong");
  dest_select_a: assert property (!$past(i_reset) |->
    o_selects.destination_register_index == $past(i_fields.destination_register_field))
    else $error("register index wrong");
  vector_select_a: assert property (!$past(i_reset) |->
    o_selects.float_vector_register == {$past(i_fields.vector_field), 2'h0})
    else $error("vector base wrong");
endmodule
bind eag_effective_address_generator eag_props chk (.i_mclk(i_mclk), .i_reset(i_reset),
  .i_addr_req(i_addr_req), .i_imm_req(i_imm_req), .i_fields(i_fields),
  .i_privileged_mode(i_privileged_mode), .o_addr_valid(o_addr_valid), .o_addr(o_addr),
  .o_privilege_fault(o_privilege_fault), .o_imm_valid(o_imm_valid), .o_imm(o_imm),
  .o_selects(o_selects));
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  self-checking bench: random back-to-back requests against a model.
  assumes one 40 MHz clock and results exactly one cycle after a request.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // stimulus and model
  // ----
  logic                   i_mclk = 1'b0;
  logic                   i_reset = 1'b1;
  logic                   pm = 1'b0;
  logic                   pp, av, pf, iv, acc;
  logic [31:0]            a, im, xa, xi;
  logic [31:0]            lx = '0;
  logic [31:0]            ie = '0;
  logic [159:0]           rb;
  eag_pkg::eag_addr_req_s q = '0, r, p;
  eag_pkg::eag_imm_req_s  iq = '0, k, pk;
  eag_pkg::eag_fields_s   f = '0, fl, pfl;
  eag_pkg::eag_selects_s  sel, es;
  int                     seed = 3256;
  int                     err_count = 0;
  int                     checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  eag_effective_address_generator dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr_req(q),
    .i_imm_req(iq), .i_fields(f), .i_privileged_mode(pm), .o_addr_valid(av), .o_addr(a),
    .o_privilege_fault(pf), .o_imm_valid(iv), .o_imm(im), .o_selects(sel));
  eag_lsu_model lsu (.i_mclk(i_mclk), .i_addr_valid(av), .i_addr(a));
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // address model in plain integer arithmetic; 32-bit results wrap
  function logic [31:0] ea(input eag_pkg::eag_addr_req_s e);
    int s, d;
    s = 1 << e.size;
    d = $signed(e.disp);
    case (e.mode)
      3'h0: ea = e.source_value + e.disp[3:0] * s;
      3'h1: ea = e.source_value + e.index_register_zero;
      3'h2: ea = e.global_base_register + e.disp[7:0] * s;
      3'h3: ea = e.global_base_register + e.index_register_zero;
      3'h4: ea = e.pc + 4 + d * 2;
      3'h5: ea = e.pc + 4 + e.source_value;
      3'h6: ea = (e.size == eag_pkg::SZ_LONG) ? (e.pc & 32'hFFFFFFFC) + 4 + e.disp[7:0] * 4
                                              : e.pc + 4 + e.disp[7:0] * 2;
      default: ea = 32'h0;
    endcase
  endfunction
  function logic [31:0] ix(input eag_pkg::eag_imm_req_s e);
    case (e.kind)
      eag_pkg::IMM_SIGN_EXT: ix = $signed(e.imm);
      eag_pkg::IMM_TRAP: ix = e.imm * 4;
      default: ix = {24'h0, e.imm};
    endcase
  endfunction
  // ----
  // main sequence: every mode at every size, issued back to back
  // ----
  initial begin
    repeat (4) @(posedge i_mclk);
    i_reset <= 1'b0;
    // first pass lets privilege vary and leaves three idle slots; second pass
    // runs privileged so that every mode and size is accepted at least once
    for (int i = 0; i < 65; i++) begin
      @(posedge i_mclk);
      p = q;
      pk = iq;
      pfl = f;
      pp = pm;
      rb = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      r = rb[146:0];
      r.valid = i < 64 && (i >= 32 || i % 9 != 8);
      r.mode = eag_pkg::eag_mode_e'(3'(i % 8));
      r.size = eag_pkg::eag_size_e'(2'(i / 8 % 4));
      k = {i < 64 && rb[155], 2'(i % 4), rb[154:147]};
      fl = rb[159:147];
      q <= r;
      iq <= k;
      f <= fl;
      pm <= (i >= 32) | rb[0];
      #1;
      // results of the request taken at this edge; the sink lags one cycle more
      acc = p.valid & ~(p.privileged & ~pp);
      xa = acc ? ea(p) : lx;
      xi = pk.valid ? ix(pk) : ie;
      chk("fault", {31'h0, p.valid & p.privileged & ~pp}, {31'h0, pf});
      chk("valid", {31'h0, acc}, {31'h0, av});
      chk("lsu", lx, lsu.last);
      chk("addr", xa, a);
      chk("imm valid", {31'h0, pk.valid}, {31'h0, iv});
      chk("imm", xi, im);
      lx = xa;
      ie = xi;
      es = '{pfl.destination_register_field, pfl.source_register_field, {pfl.pair_field, 1'b0},
             {pfl.pair_field, 1'b0}, pfl.pair_field, {pfl.vector_field, 2'h0}};
      chk("selects", {9'h0, es}, {9'h0, sel});
    end
    results();
  end
endmodule
`default_nettype wire
